/* File: test_master_pkg.sv */
// constants, codes and carrier types for the test bus-master port
// assumes a single bus clock shared with the arbiter and slaves
package test_master_pkg;

    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;

    localparam logic [1:0] TRANS_IDLE   = 2'h0;
    localparam logic [1:0] TRANS_BUSY   = 2'h1;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ    = 2'h3;

    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERROR = 2'h1;
    localparam logic [1:0] RESP_RETRY = 2'h2;
    localparam logic [1:0] RESP_SPLIT = 2'h3;

    localparam logic [2:0] BURST_INCR = 3'h1;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    localparam logic [4:0] BEATS_MIN = 5'h01;
    localparam logic [4:0] BEATS_RST = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [3:0] PROT_RST = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_XFER = 2'b10
    } state_t;

    // one test access: beats 1..31 (0 taken as 1), address steps by the size each beat
    typedef struct packed {
        logic              write;
        logic              lock;
        logic [3:0]        prot;
        logic [1:0]        size;
        logic [4:0]        beats;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

endpackage

/* File: test_master_port.sv */
// bus-master port of the test interface controller
// assumes arbiter, slaves and the command source all run on clk
`timescale 1ns/1ps
module test_master_port
    import test_master_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire cmd_t              cmd,
    input  wire logic [DATA_W-1:0] beat_wdata,
    output logic                   beat_take,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   rd_valid,
    output logic                   done,
    output logic                   done_error,
    output logic [ADDR_W-1:0]      test_master_address,
    output logic [2:0]             test_master_burst_type,
    output logic                   test_master_bus_request,
    input  wire logic              test_master_bus_grant,
    output logic                   test_master_lock,
    output logic [3:0]             test_master_protection,
    input  wire logic [DATA_W-1:0] test_master_read_data,
    input  wire logic              test_master_transfer_ready,
    input  wire logic [1:0]        test_master_response,
    output logic [2:0]             test_master_size,
    output logic [1:0]             test_master_transfer_type,
    output logic [DATA_W-1:0]      test_master_write_data,
    output logic                   test_master_direction
);

    typedef struct packed {
        state_t            state;
        cmd_t              cmd;
        logic [1:0]        trans;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] dph_addr;
        logic              dph;
        logic              replay;
        logic [4:0]        left;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              done;
        logic              err;
        logic              busreq;
    } regs_t;

    localparam regs_t REGS_RST = '{
        state:    ST_IDLE,
        cmd:      '0,
        trans:    TRANS_IDLE,
        addr:     ADDR_RST,
        dph_addr: ADDR_RST,
        dph:      1'b0,
        replay:   1'b0,
        left:     BEATS_RST,
        wdata:    DATA_RST,
        rdata:    DATA_RST,
        rvalid:   1'b0,
        done:     1'b0,
        err:      1'b0,
        busreq:   1'b0
    };

    regs_t q;
    regs_t d;

    // byte step for one beat of the given size
    function automatic logic [ADDR_W-1:0] step(input logic [1:0] size);
        logic [ADDR_W-1:0] one;
        one  = 32'h0000_0001;
        step = one << size;
    endfunction

    logic hready;
    logic grant;
    logic aph_taken;
    logic bad_resp;
    logic retry_resp;

    assign hready = test_master_transfer_ready;
    assign grant  = test_master_bus_grant;
    // an address phase is only accepted on a ready cycle
    assign aph_taken  = hready && (q.trans != TRANS_IDLE);
    assign bad_resp   = q.dph && !hready &&
                        (test_master_response != RESP_OKAY);
    assign retry_resp = bad_resp &&
                        (test_master_response != RESP_ERROR);

    always_comb
    begin
        d        = q;
        d.rvalid = 1'b0;
        d.done   = 1'b0;
        d.err    = 1'b0;
        beat_take = 1'b0;
        // data phase ends on any ready cycle, or on the first cycle of a bad answer
        if (q.dph && hready)
        begin
            d.dph = 1'b0;
            if (!q.cmd.write)
            begin
                d.rdata  = test_master_read_data;
                d.rvalid = 1'b1;
            end
        end
        // the accepted beat moves into its data phase
        if (aph_taken)
        begin
            d.dph      = 1'b1;
            d.dph_addr = q.addr;
            d.addr     = q.addr + step(q.cmd.size);
            d.left     = q.left - BEATS_MIN;
            d.replay   = 1'b0;
            if (!q.replay)
            begin
                d.wdata   = beat_wdata;
                beat_take = q.cmd.write;
            end
            if (q.left == BEATS_MIN)
            begin
                d.trans  = TRANS_IDLE;
                d.busreq = 1'b0;
            end
            else if (!grant)
            begin
                // grant lost: stop and re-arbitrate for the rest
                d.trans = TRANS_IDLE;
                d.state = ST_REQ;
            end
            else
            begin
                d.trans = TRANS_SEQ;
            end
        end
        case (q.state)
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    d.cmd    = cmd;
                    d.addr   = cmd.addr;
                    d.left   = (cmd.beats == BEATS_RST) ? BEATS_MIN
                                                        : cmd.beats;
                    d.busreq = 1'b1;
                    d.state  = ST_REQ;
                end
            end
            ST_REQ:
            begin
                d.busreq = 1'b1;
                // ownership passes only at the end of a ready cycle
                if (hready && grant && !bad_resp && !q.dph)
                begin
                    d.trans = TRANS_NONSEQ;
                    d.state = ST_XFER;
                end
            end
            ST_XFER:
            begin
                if (q.trans == TRANS_IDLE && q.left == BEATS_RST &&
                    (!q.dph || hready))
                begin
                    d.done  = 1'b1;
                    d.state = ST_IDLE;
                end
            end
            default:
            begin
                d = REGS_RST;
            end
        endcase
        // first response cycle: cancel the pending address phase
        if (bad_resp)
        begin
            d.trans = TRANS_IDLE;
            d.dph   = 1'b0;
            d.rvalid = 1'b0;
            if (retry_resp)
            begin
                // rewind to the refused beat; any beat in address
                // phase was not yet accepted so it is not counted
                d.addr   = q.dph_addr;
                d.left   = q.left + BEATS_MIN;
                d.replay = 1'b1;
                d.busreq = 1'b1;
                d.state  = ST_REQ;
            end
            else
            begin
                d.left   = BEATS_RST;
                d.busreq = 1'b0;
                d.done   = 1'b1;
                d.err    = 1'b1;
                d.state  = ST_IDLE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= REGS_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign cmd_ready  = (q.state == ST_IDLE);
    assign rd_data    = q.rdata;
    assign rd_valid   = q.rvalid;
    assign done       = q.done;
    assign done_error = q.err;

    assign test_master_address       = q.addr;
    assign test_master_burst_type    = BURST_INCR;
    assign test_master_bus_request   = q.busreq;
    assign test_master_lock          = q.cmd.lock &&
                                       (q.state != ST_IDLE);
    assign test_master_protection    = q.cmd.prot;
    assign test_master_size          = {1'b0, q.cmd.size};
    assign test_master_transfer_type = q.trans;
    assign test_master_write_data    = q.wdata;
    assign test_master_direction     = q.cmd.write;

    // checks
    burst_incr_a: assert property (@(posedge clk) disable iff (!rst_n)
        test_master_burst_type == BURST_INCR)
        else $error("burst type is not incrementing");

    req_pending_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.state == ST_REQ |-> test_master_bus_request)
        else $error("bus needed but not requested");

    grant_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        test_master_transfer_type == TRANS_NONSEQ &&
        $past(test_master_transfer_type) == TRANS_IDLE
        |-> $past(hready) && $past(grant))
        else $error("transfer started without ready grant");

    lock_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        (q.state != ST_IDLE) ##1 (q.state != ST_IDLE)
        |-> $stable(test_master_lock))
        else $error("lock changed inside a command");

    retry_cancel_a: assert property (@(posedge clk) disable iff (!rst_n)
        bad_resp |=> test_master_transfer_type == TRANS_IDLE && !rd_valid)
        else $error("address phase not cancelled on bad response");

    size_word_a: assert property (@(posedge clk) disable iff (!rst_n)
        test_master_size <= {1'b0, SIZE_WORD})
        else $error("size larger than a word");

    no_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        test_master_transfer_type != TRANS_BUSY)
        else $error("busy transfer issued");

    read_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.dph && hready && !test_master_direction
        |=> rd_valid && rd_data == $past(test_master_read_data))
        else $error("read data not captured");

    wait_state_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.dph && !hready && !bad_resp |=> !rd_valid && !done)
        else $error("transfer completed while not ready");

    hold_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
        (test_master_transfer_type != TRANS_IDLE) && !hready && !bad_resp
        |=> $stable(test_master_address) && $stable(test_master_write_data)
            && $stable(test_master_transfer_type))
        else $error("address phase changed while not ready");

    reissue_a: assert property (@(posedge clk) disable iff (!rst_n)
        retry_resp |=> test_master_address == $past(q.dph_addr))
        else $error("retried beat not rewound");

    reset_idle_a: assert property (@(posedge clk)
        $rose(rst_n) |-> test_master_transfer_type == TRANS_IDLE
            && !test_master_bus_request)
        else $error("not idle after reset");

    write_done_c: cover property (@(posedge clk) disable iff (!rst_n)
        done && !done_error && test_master_direction);
    read_done_c: cover property (@(posedge clk) disable iff (!rst_n)
        done && !done_error && !test_master_direction);
    retry_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
        retry_resp ##[1:20] done);
    error_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
        done_error);

endmodule

/* File: test_master_partner.sv */
// far side of the test bus-master port: arbiter plus one 16-word slave
// assumes the bench sets stall, hold and fault on the falling edge, fault only between commands
`timescale 1ns/1ps
module test_master_partner
    import test_master_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] addr,
    input  wire logic [1:0]  trans,
    input  wire logic        dir,
    input  wire logic        lock,
    input  wire logic        req,
    input  wire logic [31:0] wdata,
    input  wire logic [1:0]  stall,
    input  wire logic        hold,
    input  wire logic [1:0]  fault,
    output logic             grant,
    output logic             ready,
    output logic [1:0]       resp,
    output logic [31:0]      rdata
);
    logic [31:0] mem [0:15];
    logic [3:0]  a;
    logic [1:0]  cnt;
    logic [1:0]  code;
    logic        dp;
    logic        w;
    logic        ph;
    logic        spent;
    logic        gnt;
    initial
        foreach (mem[i]) mem[i] = 32'h0;
    // state sampled on the rising edge, outputs shown half a cycle later
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp <= 1'b0;
            spent <= 1'b0;
            gnt <= 1'b0;
        end
        else
        begin
            gnt <= req && (!hold || lock);
            if (ready)
            begin
                if (dp && w && code == RESP_OKAY)
                    mem[a] <= wdata;
                dp <= trans[1];
                a <= addr[5:2];
                w <= dir;
                cnt <= stall;
                ph <= 1'b0;
                code <= spent ? RESP_OKAY : fault;
                if (trans[1] && fault != RESP_OKAY)
                    spent <= 1'b1;
            end
            else if (cnt != 2'h0)
                cnt <= cnt - 2'h1;
            else
                ph <= 1'b1;
            if (fault == RESP_OKAY)
                spent <= 1'b0;
        end
    end
    // idle read bus toggles so stale data is never mistaken for a reply
    always @(negedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grant <= 1'b0;
            ready <= 1'b1;
            resp <= RESP_OKAY;
            rdata <= 32'h0;
        end
        else
        begin
            grant <= gnt;
            ready <= !dp || (cnt == 2'h0 && (code == RESP_OKAY || ph));
            resp <= (dp && cnt == 2'h0) ? code : RESP_OKAY;
            rdata <= (dp && cnt == 2'h0 && !w) ? mem[a] : ~rdata;
        end
    end
endmodule

/* File: test_bus_master_port_tb_top.sv */
// random and corner-case bench for the test bus-master port
// assumes the partner model stands in for arbiter and slave
`timescale 1ns/1ps
module test_bus_master_port_tb_top;
    import test_master_pkg::*;
    logic clk, rst_n, cmd_valid, cmd_ready, beat_take, rd_valid, done;
    logic done_error, req, grant, lock, ready, dir, hold, pv, lv;
    logic [31:0] beat_wdata, rd_data, addr, rdata, wdata, pa, la, exp_a;
    logic [31:0] wd [0:15];
    logic [31:0] shadow [0:15];
    logic [31:0] rq [$];
    logic [2:0]  burst, size;
    logic [3:0]  prot;
    logic [1:0]  resp, trans, stall, fault;
    logic [15:0] seed = 16'h001B;
    cmd_t        cmd;
    int bad_count, num_checks, cyc, takes, rds, ci, fi;
    test_master_port dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .beat_wdata(beat_wdata),
        .beat_take(beat_take), .rd_data(rd_data), .rd_valid(rd_valid),
        .done(done), .done_error(done_error), .test_master_address(addr),
        .test_master_burst_type(burst), .test_master_bus_request(req),
        .test_master_bus_grant(grant), .test_master_lock(lock),
        .test_master_protection(prot), .test_master_read_data(rdata),
        .test_master_transfer_ready(ready), .test_master_response(resp),
        .test_master_size(size), .test_master_transfer_type(trans),
        .test_master_write_data(wdata), .test_master_direction(dir));
    test_master_partner far (.clk(clk), .rst_n(rst_n), .addr(addr),
        .trans(trans), .dir(dir), .lock(lock), .req(req), .wdata(wdata),
        .stall(stall), .hold(hold), .fault(fault), .grant(grant),
        .ready(ready), .resp(resp), .rdata(rdata));
    always #50 clk = ~clk;
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic logic [31:0] beat_addr(logic [31:0] b, int k);
        return b + (32'(k) << cmd.size);
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] ex);
        num_checks++;
        if (seen !== ex)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", what, ex, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // sampling on the rising edge sees values from before the update
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            test_done();
        end
        if (rst_n)
        begin
            check("busy", {1'b0, trans == TRANS_BUSY}, 32'h0);
            if (lv)
                check("held", addr, la);
            lv = !ready && trans[1] && resp == RESP_OKAY;
            la = addr;
            if (trans[1])
            begin
                check("burst", burst, BURST_INCR);
                check("size", size, {1'b0, cmd.size});
                check("prot", prot, cmd.prot);
                check("dir", dir, cmd.write);
                check("lock", lock, cmd.lock);
            end
            if (ready && pv && resp == RESP_OKAY)
            begin
                check("addr", pa, exp_a);
                if (cmd.write)
                    check("wdata", wdata, wd[ci]);
                ci++;
                exp_a = beat_addr(exp_a, 1);
            end
            if (ready)
            begin
                pv = trans[1];
                pa = addr;
            end
            takes += beat_take;
            fi += beat_take;
            if (rd_valid)
            begin
                rds++;
                check("rdata", rd_data, rq.pop_front());
            end
        end
    end
    always @(negedge clk)
        beat_wdata <= wd[fi[3:0]];
    task automatic run_cmd(logic wr, logic [1:0] sz, logic [4:0] n,
                           logic err);
        logic [31:0] r;
        logic [31:0] b;
        int t;
        @(negedge clk);
        r = {rnd(), rnd()};
        cmd = {wr, r[6], r[10:7], sz, n, 32'h0};
        cmd.addr = {26'h0, r[5:0]} & ~((32'h1 << sz) - 32'h1);
        {exp_a, ci, fi, takes, rds} = {cmd.addr, 128'h0};
        for (int k = 0; k < n; k++)
        begin
            b = beat_addr(cmd.addr, k);
            wd[k] = {rnd(), rnd()};
            if (wr)
                shadow[b[5:2]] = wd[k];
            else if (!err)
                rq.push_back(shadow[b[5:2]]);
        end
        check("idle", cmd_ready, 1'b1);
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        check("request", req, 1'b1);
        for (t = 0; t < 500 && done !== 1'b1; t++)
        begin
            r = rnd();
            stall = r[1:0];
            hold = r[2] & r[3];
            @(negedge clk);
        end
        check("done", t < 500, 1'b1);
        // the error flag stands only in the cycle of done
        check("error", done_error, err);
        @(negedge clk);
        check("takes", takes, wr ? n : 0);
        check("reads", rds, (wr || err) ? 0 : n);
        check("beats", ci, err ? 0 : n);
        check("left", rq.size(), 0);
    endtask
    initial
    begin
        {clk, rst_n, cmd_valid, hold, pv, lv, stall, fault} = '0;
        cmd = '0;
        foreach (shadow[i]) shadow[i] = 32'h0;
        repeat (12) @(negedge clk);
        check("req rst", req, 1'b0);
        check("trans rst", trans, TRANS_IDLE);
        rst_n = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 48; i++)
            run_cmd(i < 8 || i[0], 2'(i % 3), 5'(1 + (rnd() % 8)), 1'b0);
        $display("test random done");
        for (int c = 2; c < 6; c++)
        begin
            fault = (c < 4) ? RESP_RETRY : RESP_SPLIT;
            run_cmd(c[0], SIZE_WORD, 5'h04, 1'b0);
            fault = RESP_OKAY;
            // the slave re-arms its one-shot fault only on an okay edge
            @(negedge clk);
        end
        fault = RESP_ERROR;
        run_cmd(1'b0, SIZE_HALF, 5'h03, 1'b1);
        fault = RESP_OKAY;
        $display("test faults done");
        cmd.lock = 1'b0;
        hold = 1'b1;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        @(negedge clk);
        rst_n = 1'b0;
        {pv, lv} = 2'b00;
        @(negedge clk);
        check("req mid", req, 1'b0);
        check("trans mid", trans, TRANS_IDLE);
        rst_n = 1'b1;
        run_cmd(1'b1, SIZE_BYTE, 5'h08, 1'b0);
        $display("test midreset done");
        test_done();
    end
endmodule
